/* rtl/ftl_regs.sv */
// What this block does
// - Minimum duty code maps linearly to duty
// - Minimum duty registers read-only in automatic mode
// - Lock makes thresholds read-only, writes fail
// - Above start temperature, minimum duty then ramp
// - Any critical overtemperature forces all fans full
// - Critical limit 0x80 disables the fail-safe
// - Full duty holds until limit minus hysteresis
// - Exceeding limit by 0.25 drives pin low
// - Hysteresis nibbles: local, remote 1, remote 2
// - Below start, run minimum until start minus hysteresis
// - Hysteresis 0..15 degrees on both loops
`timescale 1ns/1ps
`default_nettype none

module ftl_regs #(
   parameter int FRAC_W = ftl_pkg::TEMP_FRAC_BITS
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   output logic WR_REFUSED,
   input wire logic AUTO_MODE,
   input wire logic CFG_LOCK,
   input wire logic [8+FRAC_W-1:0] TEMP_REMOTE1,
   input wire logic [8+FRAC_W-1:0] TEMP_LOCAL,
   input wire logic [8+FRAC_W-1:0] TEMP_REMOTE2,
   input wire logic [2:0] SPAN_FAN1,
   input wire logic [2:0] SPAN_FAN2,
   input wire logic [2:0] SPAN_FAN3,
   input wire logic OVERTEMP_PIN_IS_OUTPUT,
   input wire logic OVERTEMP_PIN_I,
   output logic OVERTEMP_PIN_O,
   output logic OVERTEMP_PIN_OE,
   output logic OVERTEMP_SENSED,
   output logic [7:0] FAN1_DUTY,
   output logic [7:0] FAN2_DUTY,
   output logic [7:0] FAN3_DUTY,
   output logic FAN1_PWM,
   output logic FAN2_PWM,
   output logic FAN3_PWM,
   output logic FAILSAFE_FULL
);
   import ftl_pkg::*;

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   // Quarter-degree resolution is needed for the overtemp pin margin
   if (FRAC_W < 2 || FRAC_W > 6) begin : g_bad_frac
      $error("FRAC_W must lie between 2 and 6");
   end

   // ----------------------------------------------------------------
   // Register storage, channel 0 remote 1, 1 local, 2 remote 2
   // ----------------------------------------------------------------
   logic [7:0] min_duty [NUM_CHAN];
   logic [7:0] start_temp [NUM_CHAN];
   logic [7:0] crit_limit [NUM_CHAN];
   logic [3:0] remote1_hyst_field;
   logic [3:0] local_hyst_field;
   logic [3:0] remote2_hyst_field;
   logic [7:0] pwm_cnt;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [NUM_CHAN-1:0] hit_min, hit_start, hit_crit;
   logic [NUM_CHAN-1:0] wr_min, wr_start, wr_crit;
   logic hit_hyst1, hit_hyst2, wr_hyst1, wr_hyst2;
   logic hit_locked, refuse, hit_any;

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_dec
      assign hit_min[g] = (REG_ADDR == OFS_MIN_DUTY1 + 8'(g));
      assign hit_start[g] = (REG_ADDR == OFS_START_REMOTE1 + 8'(g));
      assign hit_crit[g] = (REG_ADDR == OFS_CRIT_REMOTE1 + 8'(g));
      assign wr_min[g] = REG_WR && hit_min[g] && !AUTO_MODE;
      assign wr_start[g] = REG_WR && hit_start[g] && !CFG_LOCK;
      assign wr_crit[g] = REG_WR && hit_crit[g] && !CFG_LOCK;
   end

   assign hit_hyst1 = (REG_ADDR == OFS_HYST_R1_LOCAL);
   assign hit_hyst2 = (REG_ADDR == OFS_HYST_REMOTE2);
   assign wr_hyst1 = REG_WR && hit_hyst1 && !CFG_LOCK;
   assign wr_hyst2 = REG_WR && hit_hyst2 && !CFG_LOCK;
   assign hit_locked = (|hit_start) || (|hit_crit) || hit_hyst1 || hit_hyst2;
   assign hit_any = (|hit_min) || hit_locked;

   // A refused write leaves contents alone and raises a one-cycle pulse
   assign refuse = REG_WR && (((|hit_min) && AUTO_MODE) || (hit_locked && CFG_LOCK));

   // ----------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------
   logic [7:0] hyst1_byte, hyst2_byte, rd_mux;

   // Low nibble of the second hysteresis register is unused and reads zero
   assign hyst1_byte = {remote1_hyst_field, local_hyst_field};
   assign hyst2_byte = {remote2_hyst_field, 4'h0};

   assign rd_mux = hit_min[0] ? min_duty[0] :
                   hit_min[1] ? min_duty[1] :
                   hit_min[2] ? min_duty[2] :
                   hit_start[0] ? start_temp[0] :
                   hit_start[1] ? start_temp[1] :
                   hit_start[2] ? start_temp[2] :
                   hit_crit[0] ? crit_limit[0] :
                   hit_crit[1] ? crit_limit[1] :
                   hit_crit[2] ? crit_limit[2] :
                   hit_hyst1 ? hyst1_byte :
                   hit_hyst2 ? hyst2_byte : DATA_ZERO;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            min_duty[i] <= RST_MIN_DUTY;
            start_temp[i] <= RST_START_TEMP;
            crit_limit[i] <= RST_CRIT_LIMIT;
         end
      end else if (CE) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (wr_min[i]) begin
               min_duty[i] <= REG_WDATA;
            end
            if (wr_start[i]) begin
               start_temp[i] <= REG_WDATA;
            end
            if (wr_crit[i]) begin
               crit_limit[i] <= REG_WDATA;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         remote1_hyst_field <= RST_HYST_R1_LOCAL[REMOTE1_HYST_LSB +: HYST_W];
         local_hyst_field <= RST_HYST_R1_LOCAL[LOCAL_HYST_LSB +: HYST_W];
         remote2_hyst_field <= RST_HYST_REMOTE2[REMOTE2_HYST_LSB +: HYST_W];
      end else if (CE) begin
         if (wr_hyst1) begin
            remote1_hyst_field <= REG_WDATA[REMOTE1_HYST_LSB +: HYST_W];
            local_hyst_field <= REG_WDATA[LOCAL_HYST_LSB +: HYST_W];
         end
         if (wr_hyst2) begin
            remote2_hyst_field <= REG_WDATA[REMOTE2_HYST_LSB +: HYST_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read answer and refusal pulse
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         REG_RDATA <= DATA_ZERO;
         REG_RVALID <= 1'b0;
         WR_REFUSED <= 1'b0;
      end else if (CE) begin
         REG_RVALID <= REG_RD;
         WR_REFUSED <= refuse;
         if (REG_RD) begin
            REG_RDATA <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel threshold logic
   // ----------------------------------------------------------------
   logic [8+FRAC_W-1:0] temp_ch [NUM_CHAN];
   logic [3:0] hyst_ch [NUM_CHAN];
   logic [2:0] span_ch [NUM_CHAN];
   logic [NUM_CHAN-1:0] fan_on, crit, over;
   logic [7:0] delta [NUM_CHAN];

   assign temp_ch[0] = TEMP_REMOTE1;
   assign temp_ch[1] = TEMP_LOCAL;
   assign temp_ch[2] = TEMP_REMOTE2;
   assign hyst_ch[0] = remote1_hyst_field;
   assign hyst_ch[1] = local_hyst_field;
   assign hyst_ch[2] = remote2_hyst_field;
   assign span_ch[0] = SPAN_FAN1;
   assign span_ch[1] = SPAN_FAN2;
   assign span_ch[2] = SPAN_FAN3;

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      ftl_chan #(
         .FRAC_W(FRAC_W)
      ) u_chan (
         .clk(CORE_CLK),
         .rstn(RSTN),
         .ce(CE),
         .temp_q(temp_ch[g]),
         .start(start_temp[g]),
         .limit(crit_limit[g]),
         .hyst(hyst_ch[g]),
         .fan_on(fan_on[g]),
         .crit(crit[g]),
         .over(over[g]),
         .delta(delta[g])
      );
   end

   // ----------------------------------------------------------------
   // Fan drive, fan n follows channel n-1
   // ----------------------------------------------------------------
   logic any_crit;
   logic [7:0] duty [NUM_CHAN];
   logic [NUM_CHAN-1:0] pwm;
   logic [7:0] next_pwm_cnt;

   // One critical channel drives every fan, not only its own
   assign any_crit = |crit;
   assign next_pwm_cnt = (pwm_cnt == PWM_LAST) ? DATA_ZERO : pwm_cnt + 8'h01;

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_fan
      ftl_duty u_duty (
         .auto_mode(AUTO_MODE),
         .failsafe(any_crit),
         .fan_on(fan_on[g]),
         .min_duty(min_duty[g]),
         .delta(delta[g]),
         .span(span_ch[g]),
         .pwm_cnt(pwm_cnt),
         .duty(duty[g]),
         .pwm(pwm[g])
      );
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         pwm_cnt <= DATA_ZERO;
         FAN1_DUTY <= DUTY_OFF;
         FAN2_DUTY <= DUTY_OFF;
         FAN3_DUTY <= DUTY_OFF;
         FAN1_PWM <= 1'b0;
         FAN2_PWM <= 1'b0;
         FAN3_PWM <= 1'b0;
         FAILSAFE_FULL <= 1'b0;
      end else if (CE) begin
         pwm_cnt <= next_pwm_cnt;
         FAN1_DUTY <= duty[0];
         FAN2_DUTY <= duty[1];
         FAN3_DUTY <= duty[2];
         FAN1_PWM <= pwm[0];
         FAN2_PWM <= pwm[1];
         FAN3_PWM <= pwm[2];
         FAILSAFE_FULL <= any_crit;
      end
   end

   // ----------------------------------------------------------------
   // Overtemperature pin, open drain, only ever pulled low
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         OVERTEMP_PIN_O <= 1'b0;
         OVERTEMP_PIN_OE <= 1'b0;
         OVERTEMP_SENSED <= 1'b0;
      end else if (CE) begin
         OVERTEMP_PIN_O <= 1'b0;
         OVERTEMP_PIN_OE <= OVERTEMP_PIN_IS_OUTPUT && (|over);
         OVERTEMP_SENSED <= !OVERTEMP_PIN_I;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_min_readonly: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_WR && AUTO_MODE && (|hit_min)) |=> ($stable(min_duty[0])
         && $stable(min_duty[1]) && $stable(min_duty[2])))
      else $error("minimum duty changed by a write in automatic mode");

   a_lock_refuse: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_WR && CFG_LOCK && REG_ADDR == OFS_CRIT_LOCAL)
      |=> ($stable(crit_limit[1]) && WR_REFUSED))
      else $error("locked critical limit changed or write not refused");

   a_failsafe_all: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      FAILSAFE_FULL |-> (FAN1_DUTY == DUTY_FULL && FAN2_DUTY == DUTY_FULL
                         && FAN3_DUTY == DUTY_FULL))
      else $error("fail-safe active without full drive on every fan");

   a_duty_linear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ((FAN1_DUTY == DUTY_FULL) |-> FAN1_PWM) and ((FAN1_DUTY == DUTY_OFF) |-> !FAN1_PWM))
      else $error("fan drive not full at 0xFF or not off at 0x00");

   a_start_run: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && AUTO_MODE && fan_on[0]) |=> (FAN1_DUTY >= $past(min_duty[0])))
      else $error("running fan below its minimum duty");

   a_hyst_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_RD && REG_ADDR == OFS_HYST_R1_LOCAL)
      |=> (REG_RVALID && REG_RDATA == {$past(remote1_hyst_field), $past(local_hyst_field)}))
      else $error("hysteresis register read back wrong layout");

   a_refuse_pulse: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && !REG_WR) |=> !WR_REFUSED)
      else $error("refusal pulse without a write");

   a_lock_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_WR && CFG_LOCK && hit_start[2]) |=> ($stable(start_temp[2]) && WR_REFUSED))
      else $error("locked start temperature changed");

   a_lock_hyst: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_WR && CFG_LOCK && hit_hyst2) |=> $stable(remote2_hyst_field))
      else $error("locked hysteresis changed");

   a_unmapped_quiet: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && REG_WR && !hit_any) |=> !WR_REFUSED)
      else $error("write outside the bank refused");

   a_pin_input: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && !OVERTEMP_PIN_IS_OUTPUT) |=> !OVERTEMP_PIN_OE)
      else $error("overtemp pin driven while configured as input");

   a_manual_duty: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && !AUTO_MODE && !any_crit) |=> (FAN2_DUTY == $past(min_duty[1])))
      else $error("manual drive differs from minimum duty code");

   a_auto_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (CE && AUTO_MODE && !any_crit && !fan_on[2]) |=> (FAN3_DUTY == DUTY_OFF))
      else $error("automatic drive on while fan is off");

   a_pwm_period: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      pwm_cnt <= PWM_LAST)
      else $error("drive counter beyond its period");

endmodule

`default_nettype wire

/* rtl/ftl_pkg.sv */
package ftl_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MIN_DUTY1 = 8'h64;
   localparam logic [7:0] OFS_MIN_DUTY2 = 8'h65;
   localparam logic [7:0] OFS_MIN_DUTY3 = 8'h66;
   localparam logic [7:0] OFS_START_REMOTE1 = 8'h67;
   localparam logic [7:0] OFS_START_LOCAL = 8'h68;
   localparam logic [7:0] OFS_START_REMOTE2 = 8'h69;
   localparam logic [7:0] OFS_CRIT_REMOTE1 = 8'h6A;
   localparam logic [7:0] OFS_CRIT_LOCAL = 8'h6B;
   localparam logic [7:0] OFS_CRIT_REMOTE2 = 8'h6C;
   localparam logic [7:0] OFS_HYST_R1_LOCAL = 8'h6D;
   localparam logic [7:0] OFS_HYST_REMOTE2 = 8'h6E;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_MIN_DUTY = 8'h80;
   localparam logic [7:0] RST_START_TEMP = 8'h5A;
   localparam logic [7:0] RST_CRIT_LIMIT = 8'h64;
   localparam logic [7:0] RST_HYST_R1_LOCAL = 8'h44;
   localparam logic [7:0] RST_HYST_REMOTE2 = 8'h40;

   // ----------------------------------------------------------------
   // Field layout of the hysteresis registers
   // ----------------------------------------------------------------
   localparam int HYST_W = 4;
   localparam int LOCAL_HYST_LSB = 0;
   localparam int REMOTE1_HYST_LSB = 4;
   localparam int REMOTE2_HYST_LSB = 4;

   // ----------------------------------------------------------------
   // Codes and scaling
   // ----------------------------------------------------------------
   localparam logic [7:0] CRIT_DISABLE = 8'h80;
   localparam logic [7:0] DUTY_OFF = 8'h00;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   // Drive counter wraps after this count, so the period is 255 steps
   localparam logic [7:0] PWM_LAST = 8'hFE;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   // Fraction bits of the temperature inputs, 0.25 degree per step
   localparam int TEMP_FRAC_BITS = 2;
   localparam int NUM_CHAN = 3;

endpackage

/* rtl/ftl_chan.sv */
`timescale 1ns/1ps
`default_nettype none

module ftl_chan #(
   parameter int FRAC_W = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [8+FRAC_W-1:0] temp_q,
   input wire logic [7:0] start,
   input wire logic [7:0] limit,
   input wire logic [3:0] hyst,
   output logic fan_on,
   output logic crit,
   output logic over,
   output logic [7:0] delta
);
   import ftl_pkg::*;

   localparam int SW = 8 + FRAC_W + 2;

   // ----------------------------------------------------------------
   // Thresholds in quarter-degree steps
   // ----------------------------------------------------------------
   logic signed [SW-1:0] tq, start_q, run_lo_q, lim_q, crit_lo_q, over_q, hyst_q, diff;
   logic [SW-1:0] diff_deg;
   logic crit_en, next_fan_on, next_crit, next_over;
   logic [7:0] next_delta;

   assign tq = signed'({2'b00, temp_q});
   assign start_q = signed'({2'b00, start, {FRAC_W{1'b0}}});
   assign lim_q = signed'({2'b00, limit, {FRAC_W{1'b0}}});
   assign hyst_q = signed'({{(SW-4-FRAC_W){1'b0}}, hyst, {FRAC_W{1'b0}}});
   assign run_lo_q = start_q - hyst_q;
   assign crit_lo_q = lim_q - hyst_q;
   assign over_q = lim_q + signed'(SW'(1 << (FRAC_W - 2)));
   assign crit_en = (limit != CRIT_DISABLE);

   // Fan keeps running below start until start minus hysteresis
   assign next_fan_on = (tq > start_q) ? 1'b1 : (tq <= run_lo_q) ? 1'b0 : fan_on;
   assign next_crit = !crit_en ? 1'b0 : (tq > lim_q) ? 1'b1 :
                      (tq < crit_lo_q) ? 1'b0 : crit;
   assign next_over = crit_en && (tq >= over_q);

   // Whole degrees above start feed the ramp
   assign diff = tq - start_q;
   assign diff_deg = diff >>> FRAC_W;
   assign next_delta = (diff <= 0) ? DATA_ZERO :
                       (|diff_deg[SW-1:8]) ? DUTY_FULL : diff_deg[7:0];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         fan_on <= 1'b0;
         crit <= 1'b0;
         over <= 1'b0;
         delta <= DATA_ZERO;
      end else if (ce) begin
         fan_on <= next_fan_on;
         crit <= next_crit;
         over <= next_over;
         delta <= next_delta;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_crit_disabled: assert property (@(posedge clk) disable iff (!rstn)
      (ce && limit == CRIT_DISABLE) |=> !crit)
      else $error("critical flag set while limit disables it");
   a_crit_hold: assert property (@(posedge clk) disable iff (!rstn)
      (ce && crit && crit_en && tq >= crit_lo_q) |=> crit)
      else $error("full drive released above limit minus hysteresis");
   a_fan_hyst: assert property (@(posedge clk) disable iff (!rstn)
      (ce && fan_on && tq > run_lo_q) |=> fan_on)
      else $error("fan stopped above start minus hysteresis");
   a_over_pin: assert property (@(posedge clk) disable iff (!rstn)
      over |-> crit)
      else $error("overtemp pin cause without critical flag");

endmodule

`default_nettype wire

/* rtl/ftl_duty.sv */
`timescale 1ns/1ps
`default_nettype none

module ftl_duty (
   input wire logic auto_mode,
   input wire logic failsafe,
   input wire logic fan_on,
   input wire logic [7:0] min_duty,
   input wire logic [7:0] delta,
   input wire logic [2:0] span,
   input wire logic [7:0] pwm_cnt,
   output logic [7:0] duty,
   output logic pwm
);
   import ftl_pkg::*;

   logic [15:0] ramp, sum;
   logic [7:0] auto_duty;

   // Ramp above minimum: degrees above start scaled by the span setting
   assign ramp = {8'h00, delta} << span;
   assign sum = {8'h00, min_duty} + ramp;
   assign auto_duty = (|sum[15:8]) ? DUTY_FULL : sum[7:0];
   assign duty = failsafe ? DUTY_FULL : !auto_mode ? min_duty :
                 !fan_on ? DUTY_OFF : auto_duty;
   // Period of 255 steps makes the code linear, 0xFF stays high
   assign pwm = (pwm_cnt < duty);

endmodule

`default_nettype wire

/* testbench/ftl_host.sv */
`timescale 1ns/1ps
`default_nettype none

module ftl_host (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output logic [7:0] addr,
   output logic wr,
   output logic [7:0] wdata,
   output logic rd
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
      rd = 1'b0;
   end

   // ----------------------------------------------------------------
   // Accesses: one strobe cycle, released after the taking edge
   // ----------------------------------------------------------------
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // Small hysteresis makes the fan cycle, so never program under four
      if ((a == 8'h6D || a == 8'h6E) && v[7:4] < 4'h4) v[7:4] = 4'h4;
      if (a == 8'h6D && v[3:0] < 4'h4) v[3:0] = 4'h4;
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      // Released lines do not keep the last value
      addr = ~a;
      wdata = ~v;
   endtask

   task automatic read(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      d = rvalid === 1'b1 ? rdata : 8'hXX;
      // Let an edge pass so a following request never reuses this time step
      @(posedge clk);
      #1;
   endtask
endmodule

`default_nettype wire

/* testbench/tb_ftl_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_ftl_regs;
   import ftl_pkg::*;
   logic clk, rstn, ce, auto_mode, cfg_lock, pin_out, ext_low;
   logic [9:0] t_r1, t_lc, t_r2;
   logic [2:0] span1, span2, span3;
   logic [7:0] addr, wdata, rdata, duty1, duty2, duty3, got;
   logic wr, rd, rvalid, refused, pin_o, pin_oe, sensed, pwm1, pwm2, pwm3, failsafe;
   wire logic pin_i;
   int num_errors = 0;
   int checks = 0;
   localparam logic [7:0] RV [11] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A,
      8'h64, 8'h64, 8'h64, 8'h44, 8'h40};

   // Open-drain pin with pull-up; an outside party may also pull it low
   assign pin_i = !(pin_oe || ext_low);

   ftl_host u_ftl_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wr(wr),
      .wdata(wdata), .rd(rd));

   ftl_regs u_ftl_regs (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr), .REG_WR(wr),
      .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .WR_REFUSED(refused), .AUTO_MODE(auto_mode), .CFG_LOCK(cfg_lock), .TEMP_REMOTE1(t_r1),
      .TEMP_LOCAL(t_lc), .TEMP_REMOTE2(t_r2), .SPAN_FAN1(span1), .SPAN_FAN2(span2),
      .SPAN_FAN3(span3), .OVERTEMP_PIN_IS_OUTPUT(pin_out), .OVERTEMP_PIN_I(pin_i),
      .OVERTEMP_PIN_O(pin_o), .OVERTEMP_PIN_OE(pin_oe), .OVERTEMP_SENSED(sensed),
      .FAN1_DUTY(duty1), .FAN2_DUTY(duty2), .FAN3_DUTY(duty3), .FAN1_PWM(pwm1),
      .FAN2_PWM(pwm2), .FAN3_PWM(pwm3), .FAILSAFE_FULL(failsafe));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic wr_exp(input logic [7:0] a, input logic [7:0] d, input logic exp_ref);
      logic seen;
      seen = 1'b0;
      u_ftl_host.write(a, d);
      for (int i = 0; i < 3; i++) begin
         seen |= (refused === 1'b1);
         @(posedge clk);
         #1;
      end
      check("write refused", {7'd0, seen}, {7'd0, exp_ref});
   endtask

   // Temperatures in whole degrees; thermal path answers within two edges
   task automatic temps(input int r1, input int lc, input int r2);
      t_r1 = 10'(r1 * 4);
      t_lc = 10'(lc * 4);
      t_r2 = 10'(r2 * 4);
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic chk_duty(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] d3);
      check("fan1 duty", duty1, d1);
      check("fan2 duty", duty2, d2);
      check("fan3 duty", duty3, d3);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      for (int i = 0; i < 11; i++) begin
         u_ftl_host.read(8'(8'h64 + i), got);
         check("reset value", got, RV[i]);
      end
      u_ftl_host.read(8'h6F, got);
      check("unmapped read", got, 8'h00);
   endtask

   task automatic t_mode_lock();
      auto_mode = 1'b1;
      wr_exp(8'h64, 8'h11, 1'b1);
      u_ftl_host.read(8'h64, got);
      check("min duty in auto", got, 8'h80);
      auto_mode = 1'b0;
      wr_exp(8'h64, 8'h40, 1'b0);
      u_ftl_host.read(8'h64, got);
      check("min duty manual", got, 8'h40);
      cfg_lock = 1'b1;
      for (int a = 8'h67; a <= 8'h6E; a++) wr_exp(8'(a), 8'h55, 1'b1);
      wr_exp(8'h6F, 8'h55, 1'b0);
      u_ftl_host.read(8'h6A, got);
      check("locked limit", got, 8'h64);
      wr_exp(8'h65, 8'h80, 1'b0);
      cfg_lock = 1'b0;
      wr_exp(8'h6D, 8'h5A, 1'b0);
   endtask

   task automatic t_manual_pwm();
      int high, high2, high3;
      high = 0;
      high2 = 0;
      high3 = 0;
      temps(20, 20, 20);
      chk_duty(8'h40, 8'h80, 8'h80);
      for (int i = 0; i < 255; i++) begin
         high += (pwm1 === 1'b1);
         high2 += (pwm2 === 1'b1);
         high3 += (pwm3 === 1'b1);
         @(posedge clk);
         #1;
      end
      check("pwm1 high steps", 8'(high), 8'h40);
      check("pwm2 high steps", 8'(high2), 8'h80);
      check("pwm3 high steps", 8'(high3), 8'h80);
   endtask

   // Clock enable low must hold every register, host writes included
   task automatic t_freeze();
      ce = 1'b0;
      u_ftl_host.write(8'h64, 8'h20);
      repeat (2) @(posedge clk);
      #1;
      ce = 1'b1;
      u_ftl_host.read(8'h64, got);
      check("frozen write", got, 8'h40);
   endtask

   task automatic t_failsafe();
      temps(20, 101, 20);
      check("failsafe on", {7'd0, failsafe}, 8'h01);
      chk_duty(DUTY_FULL, DUTY_FULL, DUTY_FULL);
      temps(20, 92, 20);
      chk_duty(DUTY_FULL, DUTY_FULL, DUTY_FULL);
      temps(20, 89, 20);
      check("failsafe off", {7'd0, failsafe}, 8'h00);
      chk_duty(8'h40, 8'h80, 8'h80);
   endtask

   task automatic t_disable();
      wr_exp(8'h6B, CRIT_DISABLE, 1'b0);
      pin_out = 1'b1;
      temps(20, 130, 20);
      check("disabled failsafe", {7'd0, failsafe}, 8'h00);
      check("disabled pin", {7'd0, pin_oe}, 8'h00);
      wr_exp(8'h6B, 8'h64, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      check("limit restored", {7'd0, failsafe}, 8'h01);
      temps(20, 20, 20);
   endtask

   task automatic t_pin();
      pin_out = 1'b1;
      temps(20, 100, 20);
      check("pin at limit", {7'd0, pin_oe}, 8'h00);
      t_lc = 10'd401;
      repeat (4) @(posedge clk);
      #1;
      check("pin driven", {7'd0, pin_oe}, 8'h01);
      check("pin level", {7'd0, pin_o}, 8'h00);
      check("pin sensed", {7'd0, sensed}, 8'h01);
      pin_out = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check("pin as input", {7'd0, pin_oe}, 8'h00);
      ext_low = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("outside pull", {7'd0, sensed}, 8'h01);
      ext_low = 1'b0;
      temps(20, 20, 20);
   endtask

   task automatic t_auto();
      auto_mode = 1'b1;
      span1 = 3'd1;
      temps(20, 20, 20);
      chk_duty(DUTY_OFF, DUTY_OFF, DUTY_OFF);
      temps(95, 20, 20);
      chk_duty(8'h4A, DUTY_OFF, DUTY_OFF);
      temps(88, 20, 20);
      chk_duty(8'h40, DUTY_OFF, DUTY_OFF);
      temps(86, 20, 20);
      chk_duty(8'h40, DUTY_OFF, DUTY_OFF);
      temps(85, 20, 20);
      chk_duty(DUTY_OFF, DUTY_OFF, DUTY_OFF);
      auto_mode = 1'b0;
   endtask

   initial begin
      #300000;
      num_errors++;
      results();
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      auto_mode = 1'b0;
      cfg_lock = 1'b0;
      pin_out = 1'b0;
      ext_low = 1'b0;
      t_r1 = 10'd0;
      t_lc = 10'd0;
      t_r2 = 10'd0;
      span1 = 3'd0;
      span2 = 3'd0;
      span3 = 3'd0;
      repeat (12) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset_values();
      t_mode_lock();
      t_manual_pwm();
      t_freeze();
      t_failsafe();
      t_disable();
      t_pin();
      t_auto();
      results();
   end
endmodule

`default_nettype wire
